// *** core/apc_regs_top.v ***
// register bank and setting decode for analog loop 0.
// assumes a one-cycle write/read strobe port on clk_in and a digital loop
// state field that comes from logic on the same clock.
//
// Implementation choice: the strobed register port.
`include "apc_consts.vh"

module apc_regs_top #(
	parameter [1:0] FREERUN_STATE = 2'h1
) (
	input  wire        clk_in,
	input  wire        reset_in,
	input  wire [15:0] addr_in,
	input  wire [7:0]  wdata_in,
	input  wire        wr_in,
	input  wire        rd_in,
	output wire [7:0]  rdata_out,
	input  wire [1:0]  digital_loop_state_in,
	output wire [2:0]  pump_current_sel_out,
	output wire [9:0]  pump_current_ua_out,
	output wire [1:0]  series_resistor_sel_out,
	output wire [10:0] series_resistor_ohm_out,
	output wire [1:0]  parallel_cap_sel_out,
	output wire [7:0]  parallel_cap_pf_out,
	output wire        second_pole_sel_out,
	output wire [10:0] post_resistor_ohm_out,
	output wire        lock_count_accuracy_out,
	output wire [4:0]  lock_ppm_out,
	output wire        lock_manual_override_out,
	output wire        manual_vco_choice_out,
	output wire [4:0]  first_vco_lock_code_out,
	output wire [4:0]  second_vco_lock_code_out,
	output wire        manual_lock_active_out,
	output wire [4:0]  applied_lock_code_out,
	output wire        first_oscillator_sel_out,
	output wire        second_oscillator_sel_out,
	output wire        synth_only_mode_out,
	output wire        track_refs_out,
	output wire        synth_state_fault_out,
	output wire        cfg_write_out
);
	// ------------------------------------------------------------------
	// decode tables
	// ------------------------------------------------------------------
	localparam [10:0] RES_OHM_0  = 11'h14a;
	localparam [10:0] RES_OHM_1  = 11'h280;
	localparam [10:0] RES_OHM_2  = 11'h4b0;
	localparam [10:0] RES_OHM_3  = 11'h6fe;
	localparam [7:0]  CAP_PF_0   = 8'h28;
	localparam [7:0]  CAP_PF_1   = 8'h50;
	localparam [7:0]  CAP_PF_2   = 8'h8c;
	localparam [7:0]  CAP_PF_3   = 8'hc8;
	localparam [10:0] POST_LO    = 11'h1f1;
	localparam [10:0] POST_HI    = 11'h62c;
	localparam [4:0]  PPM_FINE   = 5'h01;
	localparam [4:0]  PPM_COARSE = 5'h10;
	localparam [9:0]  PUMP_STEP  = 10'h06e;

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------
	wire       hit_pump;
	wire       hit_mode;
	wire       hit_code1;
	wire       hit_code2;
	wire       hit_stat;
	wire [7:0] pump_filter_q;
	wire [7:0] lock_mode_q;
	wire [7:0] vco_code1_q;
	wire [7:0] vco_code2_q;

	assign hit_pump  = (addr_in == `APC_PUMP_FILTER_OFS);
	assign hit_mode  = (addr_in == `APC_LOCK_MODE_OFS);
	assign hit_code1 = (addr_in == `APC_VCO_CODE1_OFS);
	assign hit_code2 = (addr_in == `APC_VCO_CODE2_OFS);
	assign hit_stat  = (addr_in == `APC_STATUS_OFS);

	// ------------------------------------------------------------------
	// storage
	// ------------------------------------------------------------------
	// masks clear reserved positions on every write
	apc_field_reg #(
		.RST_VAL (`APC_PUMP_FILTER_RST),
		.WR_MASK (`APC_PUMP_FILTER_MASK)
	) u_pump_filter (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.wr_en_in (wr_in & hit_pump),
		.wdata_in (wdata_in),
		.q_out    (pump_filter_q)
	);

	apc_field_reg #(
		.RST_VAL (`APC_LOCK_MODE_RST),
		.WR_MASK (`APC_LOCK_MODE_MASK)
	) u_lock_mode (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.wr_en_in (wr_in & hit_mode),
		.wdata_in (wdata_in),
		.q_out    (lock_mode_q)
	);

	apc_field_reg #(
		.RST_VAL (`APC_VCO_CODE1_RST),
		.WR_MASK (`APC_VCO_CODE1_MASK)
	) u_vco_code1 (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.wr_en_in (wr_in & hit_code1),
		.wdata_in (wdata_in),
		.q_out    (vco_code1_q)
	);

	apc_field_reg #(
		.RST_VAL (`APC_VCO_CODE2_RST),
		.WR_MASK (`APC_VCO_CODE2_MASK)
	) u_vco_code2 (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.wr_en_in (wr_in & hit_code2),
		.wdata_in (wdata_in),
		.q_out    (vco_code2_q)
	);

	// ------------------------------------------------------------------
	// raw fields
	// ------------------------------------------------------------------
	wire [2:0] pump_sel;
	wire [1:0] res_sel;
	wire [1:0] cap_sel;
	wire       pole_sel;
	wire       lcnt;
	wire       ovr;
	wire       synth;
	wire       vco_choice;
	wire [4:0] code1;
	wire [4:0] code2;

	assign pump_sel   = pump_filter_q[`APC_PUMP_MSB:`APC_PUMP_LSB];
	assign res_sel    = pump_filter_q[`APC_SERIES_MSB:`APC_SERIES_LSB];
	assign cap_sel    = pump_filter_q[`APC_CAP_MSB:`APC_CAP_LSB];
	assign pole_sel   = pump_filter_q[`APC_POLE_BIT];
	assign lcnt       = lock_mode_q[`APC_LCNT_BIT];
	assign ovr        = lock_mode_q[`APC_OVR_BIT];
	assign synth      = lock_mode_q[`APC_SYNTH_BIT];
	assign vco_choice = vco_code1_q[`APC_VCO_BIT];
	assign code1      = vco_code1_q[`APC_CODE_MSB:`APC_CODE_LSB];
	assign code2      = vco_code2_q[`APC_CODE_MSB:`APC_CODE_LSB];

	// ------------------------------------------------------------------
	// decode of analog settings
	// ------------------------------------------------------------------
	reg [9:0]  pump_ua_next;
	reg [10:0] res_ohm_next;
	reg [7:0]  cap_pf_next;
	reg [10:0] post_ohm_next;
	reg [4:0]  ppm_next;

	// equal current steps: code n gives (n + 1) times the lowest current
	always @* begin
		pump_ua_next = PUMP_STEP * ({7'h00, pump_sel} + 10'h001);
	end

	always @* begin
		case (res_sel)
			2'h0: res_ohm_next = RES_OHM_0;
			2'h1: res_ohm_next = RES_OHM_1;
			2'h2: res_ohm_next = RES_OHM_2;
			2'h3: res_ohm_next = RES_OHM_3;
			default: res_ohm_next = RES_OHM_1;
		endcase
	end

	always @* begin
		case (cap_sel)
			2'h0: cap_pf_next = CAP_PF_0;
			2'h1: cap_pf_next = CAP_PF_1;
			2'h2: cap_pf_next = CAP_PF_2;
			2'h3: cap_pf_next = CAP_PF_3;
			default: cap_pf_next = CAP_PF_1;
		endcase
	end

	// post capacitor is fixed; only the resistor moves
	always @* begin
		post_ohm_next = pole_sel ? POST_HI : POST_LO;
	end

	// the bit itself follows the external capacitor choice made by software
	always @* begin
		ppm_next = lcnt ? PPM_COARSE : PPM_FINE;
	end

	// ------------------------------------------------------------------
	// lock control path
	// ------------------------------------------------------------------
	reg [4:0] lock_code_next;
	reg       first_osc_next;
	reg       second_osc_next;

	// in automatic mode the loop picks its own oscillator, so both
	// manual selects stay low and no code is driven
	always @* begin
		lock_code_next  = 5'h00;
		first_osc_next  = 1'b0;
		second_osc_next = 1'b0;
		if (ovr) begin
			if (vco_choice) begin
				first_osc_next = 1'b1;
				lock_code_next = code1;
			end else begin
				second_osc_next = 1'b1;
				lock_code_next  = code2;
			end
		end
	end

	// ------------------------------------------------------------------
	// synthesizer mode check
	// ------------------------------------------------------------------
	wire fault_next;

	// only flags the software slip; the device keeps running as programmed
	assign fault_next = synth & (digital_loop_state_in != FREERUN_STATE);

	// ------------------------------------------------------------------
	// output registers
	// ------------------------------------------------------------------
	reg [9:0]  pump_ua_reg;
	reg [10:0] res_ohm_reg;
	reg [7:0]  cap_pf_reg;
	reg [10:0] post_ohm_reg;
	reg [4:0]  ppm_reg;
	reg [4:0]  lock_code_reg;
	reg        manual_reg;
	reg        first_osc_reg;
	reg        second_osc_reg;
	reg        synth_reg;
	reg        track_reg;
	reg        fault_reg;
	reg        write_reg;

	// decoded values lag the register by one cycle; all reset to the
	// values implied by the register defaults
	always @(posedge clk_in) begin
		if (reset_in) begin
			pump_ua_reg    <= 10'h226;
			res_ohm_reg    <= RES_OHM_1;
			cap_pf_reg     <= CAP_PF_1;
			post_ohm_reg   <= POST_HI;
			ppm_reg        <= PPM_COARSE;
			lock_code_reg  <= 5'h00;
			manual_reg     <= 1'b0;
			first_osc_reg  <= 1'b0;
			second_osc_reg <= 1'b0;
			synth_reg      <= 1'b0;
			track_reg      <= 1'b1;
			fault_reg      <= 1'b0;
			write_reg      <= 1'b0;
		end else begin
			pump_ua_reg    <= pump_ua_next;
			res_ohm_reg    <= res_ohm_next;
			cap_pf_reg     <= cap_pf_next;
			post_ohm_reg   <= post_ohm_next;
			ppm_reg        <= ppm_next;
			lock_code_reg  <= lock_code_next;
			manual_reg     <= ovr;
			first_osc_reg  <= first_osc_next;
			second_osc_reg <= second_osc_next;
			synth_reg      <= synth;
			track_reg      <= ~synth;
			fault_reg      <= fault_next;
			write_reg      <= wr_in & (hit_pump | hit_mode |
				hit_code1 | hit_code2);
		end
	end

	// ------------------------------------------------------------------
	// read port
	// ------------------------------------------------------------------
	reg [7:0] rd_mux;
	reg [7:0] rdata_reg;
	wire [7:0] status_word;

	assign status_word = {4'h0, synth_reg, first_osc_reg, manual_reg,
		fault_reg};

	// reserved positions come back as zero; unmapped addresses read zero
	always @* begin
		rd_mux = 8'h00;
		if (hit_pump) begin
			rd_mux = pump_filter_q;
		end else if (hit_mode) begin
			rd_mux = lock_mode_q;
		end else if (hit_code1) begin
			rd_mux = vco_code1_q;
		end else if (hit_code2) begin
			rd_mux = vco_code2_q;
		end else if (hit_stat) begin
			rd_mux = status_word;
		end
	end

	// data stand only in the cycle after the strobe
	always @(posedge clk_in) begin
		if (reset_in) begin
			rdata_reg <= 8'h00;
		end else if (rd_in) begin
			rdata_reg <= rd_mux;
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign rdata_out                 = rdata_reg;
	assign pump_current_sel_out      = pump_sel;
	assign pump_current_ua_out       = pump_ua_reg;
	assign series_resistor_sel_out   = res_sel;
	assign series_resistor_ohm_out   = res_ohm_reg;
	assign parallel_cap_sel_out      = cap_sel;
	assign parallel_cap_pf_out       = cap_pf_reg;
	assign second_pole_sel_out       = pole_sel;
	assign post_resistor_ohm_out     = post_ohm_reg;
	assign lock_count_accuracy_out   = lcnt;
	assign lock_ppm_out              = ppm_reg;
	assign lock_manual_override_out  = ovr;
	assign manual_vco_choice_out     = vco_choice;
	assign first_vco_lock_code_out   = code1;
	assign second_vco_lock_code_out  = code2;
	assign manual_lock_active_out    = manual_reg;
	assign applied_lock_code_out     = lock_code_reg;
	assign first_oscillator_sel_out  = first_osc_reg;
	assign second_oscillator_sel_out = second_osc_reg;
	assign synth_only_mode_out       = synth_reg;
	assign track_refs_out            = track_reg;
	assign synth_state_fault_out     = fault_reg;
	assign cfg_write_out             = write_reg;
endmodule

// *** include/apc_consts.vh ***
// constants for the analog loop 0 control register bank: offsets, field
// positions and reset values.
// assumes a byte-wide register port with a 16-bit address.
`ifndef APC_CONSTS_VH
`define APC_CONSTS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define APC_PUMP_FILTER_OFS   16'h00ac
`define APC_LOCK_MODE_OFS     16'h00ad
`define APC_VCO_CODE1_OFS     16'h00ae
`define APC_VCO_CODE2_OFS     16'h00af
`define APC_STATUS_OFS        16'h00f0

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define APC_PUMP_MSB          7
`define APC_PUMP_LSB          5
`define APC_SERIES_MSB        4
`define APC_SERIES_LSB        3
`define APC_CAP_MSB           2
`define APC_CAP_LSB           1
`define APC_POLE_BIT          0
`define APC_SYNTH_BIT         3
`define APC_LCNT_BIT          1
`define APC_OVR_BIT           0
`define APC_VCO_BIT           5
`define APC_CODE_MSB          4
`define APC_CODE_LSB          0

// ----------------------------------------------------------------------
// writable bit masks (reserved positions kept at zero)
// ----------------------------------------------------------------------
`define APC_PUMP_FILTER_MASK  8'hff
`define APC_LOCK_MODE_MASK    8'h0b
`define APC_VCO_CODE1_MASK    8'h3f
`define APC_VCO_CODE2_MASK    8'h1f

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define APC_PUMP_FILTER_RST   8'h8b
`define APC_LOCK_MODE_RST     8'h02
`define APC_VCO_CODE1_RST     8'h2b
`define APC_VCO_CODE2_RST     8'h00

`endif

// *** core/apc_field_reg.v ***
// one byte-wide configuration register with reset value and write mask.
// assumes write strobe and data from logic on the same clock.
module apc_field_reg #(
	parameter [7:0] RST_VAL = 8'h00,
	parameter [7:0] WR_MASK = 8'hff
) (
	input  wire       clk_in,
	input  wire       reset_in,
	input  wire       wr_en_in,
	input  wire [7:0] wdata_in,
	output wire [7:0] q_out
);
	reg [7:0] q_reg;

	// masked bits never store a one, so reserved positions stay clear
	always @(posedge clk_in) begin
		if (reset_in) begin
			q_reg <= RST_VAL;
		end else if (wr_en_in) begin
			q_reg <= wdata_in & WR_MASK;
		end
	end

	assign q_out = q_reg;
endmodule

// *** sim/apc_regs_sva.sv ***
// checker for the loop 0 register bank, watching top-level ports only.
// assumes it is bound onto apc_regs_top and shares its clock and reset.
module apc_regs_sva #(
	parameter [1:0] FREERUN_STATE = 2'h1
) (
	input wire logic        clk_in,
	input wire logic        reset_in,
	input wire logic [15:0] addr_in,
	input wire logic [7:0]  wdata_in,
	input wire logic        wr_in,
	input wire logic        rd_in,
	input wire logic [7:0]  rdata_out,
	input wire logic [1:0]  digital_loop_state_in,
	input wire logic [2:0]  pump_current_sel_out,
	input wire logic [9:0]  pump_current_ua_out,
	input wire logic        lock_count_accuracy_out,
	input wire logic [4:0]  lock_ppm_out,
	input wire logic        lock_manual_override_out,
	input wire logic        manual_vco_choice_out,
	input wire logic [4:0]  first_vco_lock_code_out,
	input wire logic [4:0]  second_vco_lock_code_out,
	input wire logic [4:0]  applied_lock_code_out,
	input wire logic        first_oscillator_sel_out,
	input wire logic        second_oscillator_sel_out,
	input wire logic        synth_only_mode_out,
	input wire logic        track_refs_out,
	input wire logic        synth_state_fault_out,
	input wire logic        cfg_write_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (reset_in);

	// ------------------------------------------------------------
	// access sequences
	// ------------------------------------------------------------
	sequence s_pump_wr;
		wr_in && addr_in == 16'h00ac;
	endsequence
	sequence s_rd_lock;
		rd_in && addr_in == 16'h00ad;
	endsequence
	sequence s_rd_code2;
		rd_in && addr_in == 16'h00af;
	endsequence

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	AST_PUMP_WR: assert property (s_pump_wr |=>
		pump_current_sel_out == $past(wdata_in[7:5]))
		else $error("pump field not taken from write");
	AST_PUMP_UA: assert property (pump_current_ua_out ==
		10'd110 * ({7'h0, $past(pump_current_sel_out)} + 10'd1))
		else $error("pump current decode wrong");
	AST_LOCK_PPM: assert property (lock_ppm_out ==
		($past(lock_count_accuracy_out) ? 5'd16 : 5'd1))
		else $error("lock accuracy decode wrong");
	AST_APPLIED: assert property (applied_lock_code_out ==
		(!$past(lock_manual_override_out) ? 5'h00 :
		$past(manual_vco_choice_out) ? $past(first_vco_lock_code_out) :
		$past(second_vco_lock_code_out)))
		else $error("applied lock code wrong");
	AST_OSC_SEL: assert property ($past(lock_manual_override_out) |->
		first_oscillator_sel_out == $past(manual_vco_choice_out) &&
		second_oscillator_sel_out == !$past(manual_vco_choice_out))
		else $error("oscillator select wrong");
	AST_TRACK: assert property (track_refs_out == !synth_only_mode_out)
		else $error("track and synth not opposite");
	AST_FAULT: assert property (synth_state_fault_out ==
		(synth_only_mode_out &&
		$past(digital_loop_state_in) != FREERUN_STATE))
		else $error("synth state flag wrong");
	AST_RDATA_IDLE: assert property (!rd_in |=> rdata_out == 8'h00)
		else $error("read data not idle");
	AST_RD_LOCK: assert property (s_rd_lock |=>
		rdata_out[7:4] == 4'h0 && rdata_out[2] == 1'b0 &&
		rdata_out[1] == $past(lock_count_accuracy_out) &&
		rdata_out[0] == $past(lock_manual_override_out))
		else $error("lock mode read back wrong");
	AST_RD_CODE2: assert property (s_rd_code2 |=>
		rdata_out == {3'h0, $past(second_vco_lock_code_out)})
		else $error("second code read back wrong");
	AST_CFG_WR: assert property (cfg_write_out ==
		$past(wr_in && addr_in[15:2] == 14'h002b))
		else $error("config write pulse wrong");
endmodule

bind apc_regs_top apc_regs_sva #(.FREERUN_STATE(FREERUN_STATE)) chk_u (.*);

// *** sim/analog_pll0_control_regs_tb_top.sv ***
// directed bench for the loop 0 register bank.
// assumes the checker is compiled alongside and bound to the design.
module analog_pll0_control_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_in   = 1'b0;
	logic        reset_in = 1'b1;
	logic [15:0] addr_in  = 16'h0000;
	logic [7:0]  wdata_in = 8'h00;
	logic        wr_in    = 1'b0;
	logic        rd_in    = 1'b0;
	logic [1:0]  state_in = 2'h1;
	wire  [7:0]  rdata;
	wire  [9:0]  ua;
	wire  [10:0] ohm;
	wire  [10:0] post;
	wire  [7:0]  pf;
	wire  [4:0]  ppm;
	wire  [4:0]  code;
	wire         osc1;
	wire         osc2;
	wire         synth;
	wire         track;
	wire         fault;
	wire  [1:0]  rsel;
	wire  [1:0]  csel;
	wire         pole;
	wire         man;
	int          n_mismatch  = 0;
	int          checks_done = 0;
	int          ohm_t[4]    = '{330, 640, 1200, 1790};
	int          pf_t[4]     = '{40, 80, 140, 200};

	apc_regs_top dut_u (
		.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata), .digital_loop_state_in(state_in),
		.pump_current_sel_out(), .pump_current_ua_out(ua),
		.series_resistor_sel_out(rsel), .series_resistor_ohm_out(ohm),
		.parallel_cap_sel_out(csel), .parallel_cap_pf_out(pf),
		.second_pole_sel_out(pole), .post_resistor_ohm_out(post),
		.lock_count_accuracy_out(), .lock_ppm_out(ppm),
		.lock_manual_override_out(), .manual_vco_choice_out(),
		.first_vco_lock_code_out(), .second_vco_lock_code_out(),
		.manual_lock_active_out(man), .applied_lock_code_out(code),
		.first_oscillator_sel_out(osc1),
		.second_oscillator_sel_out(osc2),
		.synth_only_mode_out(synth), .track_refs_out(track),
		.synth_state_fault_out(fault), .cfg_write_out()
	);

	// ------------------------------------------------------------
	// access tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// spaced writes: decoded outputs have landed when this returns
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
		@(posedge clk_in);
		#1;
	endtask

	task automatic rdc(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		chk(rdata, e);
	endtask

	task automatic dflt;
		rdc(16'h00ac, 8'h8b);
		rdc(16'h00ad, 8'h02);
		rdc(16'h00ae, 8'h2b);
		rdc(16'h00af, 8'h00);
		chk(ua, 11'd550);
		chk(ohm, 11'd640);
		chk(pf, 11'd80);
		chk(post, 11'd1580);
		chk(ppm, 11'd16);
		chk({code, man, synth, osc1, osc2, track}, 11'h001);
		chk({rsel, csel, pole}, 11'h00b);
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// stimulus
	// ------------------------------------------------------------
	initial begin
		forever #2 clk_in = ~clk_in;
	end

	initial begin
		repeat (20000) @(posedge clk_in);
		n_mismatch++;
		conclude;
	end

	initial begin
		repeat (5) @(posedge clk_in);
		reset_in <= 1'b0;
		dflt;
		for (int i = 0; i < 8; i++) begin
			wr(16'h00ac, {i[2:0], i[1:0], i[2:1], i[0]});
			chk({rsel, csel, pole}, {i[1:0], i[2:1], i[0]});
			chk(ua, 11'(110 * (i + 1)));
			chk(ohm, 11'(ohm_t[i % 4]));
			chk(pf, 11'(pf_t[i / 2]));
			chk(post, i[0] ? 11'd1580 : 11'd497);
			rdc(16'h00ac, {i[2:0], i[1:0], i[2:1], i[0]});
		end
		// state left off free-run so the mismatch flag must rise
		@(posedge clk_in);
		state_in <= 2'h0;
		wr(16'h00ad, 8'hff);
		rdc(16'h00ad, 8'h0b);
		chk({synth, track, fault, ppm}, {3'b101, 5'd16});
		@(posedge clk_in);
		state_in <= 2'h1;
		repeat (2) @(posedge clk_in);
		#1;
		chk(fault, 11'h000);
		wr(16'h00ad, 8'h01);
		chk({synth, track, ppm}, {2'b01, 5'd1});
		wr(16'h00ae, 8'h35);
		wr(16'h00af, 8'h0a);
		chk({man, osc1, osc2, code}, {3'b110, 5'h15});
		rdc(16'h00f0, 8'h06);
		wr(16'h00ae, 8'hd5);
		rdc(16'h00ae, 8'h15);
		chk({osc1, osc2, code}, {2'b01, 5'h0a});
		wr(16'h00ad, 8'h00);
		chk({man, osc1, osc2, code}, 11'h000);
		wr(16'h00b0, 8'h55);
		wr(16'h00f0, 8'hff);
		rdc(16'h00ac, 8'hff);
		rdc(16'h00b0, 8'h00);
		@(posedge clk_in);
		reset_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		reset_in <= 1'b0;
		dflt;
		conclude;
	end
endmodule
